// ---- dmth_top.v ----
// Contract
// - Status item shows quantity chosen by its selector, with matching unit.
// - Status item stays valid in every view mode.
// - Factory init sets status selector to frequency.
// - Three monitor line selectors choose the monitor line quantities.
// - Trip while running enters trip view mode and shows trip type.
// - Each trip captures frequency, current and run state snapshot.
// - Trip release restores the view shown before the trip.
// - Simultaneous trips show their count beside the trip type.
// - Enter key toggles pending trip list while several trips pend.
// - History keeps five newest trips, oldest discarded.
// - Reset-caused and power-off low-voltage trips are also recorded.
// - Stop/reset key or terminal input stores trip and restores view.
// - Newest stored trip in slot one; older entries shift deeper.
// - Init command resets all groups or one group to factory values.
// - After init the init selection item is presented again.
// - Reference source selector takes values zero to nine.
// - Keypad-one source uses command frequency, applied on enter key.
// - Keypad-two source steps reference up and down per key press.
// - Reference never exceeds maximum frequency; defaults to zero.
// - Voltage input one unipolar is forward only, bipolar allows reverse.
//
// The APB register port and the register addresses were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "dmth_map.vh"

module dmth_top
(
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire key_enter,
  input wire key_stop_reset,
  input wire key_up,
  input wire key_down,
  input wire term_reset,
  input wire running,
  input wire [7:0] trip_code,
  input wire [3:0] trip_count,
  input wire trip_event,
  input wire [15:0] meas_freq,
  input wire [15:0] meas_curr,
  input wire [15:0] meas_volt,
  input wire [15:0] meas_other,
  input wire [15:0] ext_ref,
  input wire ext_ref_neg,
  output reg [15:0] status_value,
  output reg [1:0] status_unit,
  output reg [15:0] mon_line1,
  output reg [15:0] mon_line2,
  output reg [15:0] mon_line3,
  output reg [2:0] view_mode,
  output reg trip_list_shown,
  output reg [15:0] freq_ref,
  output reg freq_reverse,
  output reg init_busy,
  output reg [7:0] init_group
);

  // ----------------------------------------
  // View modes
  // ----------------------------------------
  localparam [2:0] monitor_view_mode = 3'h0;
  localparam [2:0] parameter_view_mode = 3'h1;
  localparam [2:0] trip_view_mode = 3'h2;
  localparam [2:0] configuration_view_mode = 3'h3;
  localparam [2:0] init_select_mode = 3'h4;

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  reg [6:0] sy1;
  reg [6:0] sy2;
  reg [6:0] sy3;
  reg [6:0] key_lvl;
  reg [6:0] key_prev;
  wire [6:0] raw_in;
  wire [6:0] key_rise;

  assign raw_in = {trip_event, running, key_enter, key_stop_reset, key_up, key_down, term_reset};

  // Three stages; a level changes only when stages two and three agree
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sy1 <= 7'h00;
      sy2 <= 7'h00;
      sy3 <= 7'h00;
      key_lvl <= 7'h00;
      key_prev <= 7'h00;
    end
    else
    begin
      sy1 <= raw_in;
      sy2 <= sy1;
      sy3 <= sy2;
      key_lvl <= (sy2 & sy3) | (key_lvl & (sy2 | sy3));
      key_prev <= key_lvl;
    end
  end

  assign key_rise = key_lvl & ~key_prev;
  wire ev_trip = key_rise[6];
  wire run_lvl = key_lvl[5];
  wire ev_enter = key_rise[4];
  wire ev_stop = key_rise[3];
  wire ev_up = key_rise[2];
  wire ev_down = key_rise[1];
  wire ev_term = key_rise[0];

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  reg [4:0] status_sel;
  reg [4:0] mon_sel1;
  reg [4:0] mon_sel2;
  reg [4:0] mon_sel3;
  reg [3:0] ref_src;
  reg [15:0] cmd_freq;
  reg [15:0] max_freq;
  reg vin1_bipolar;
  reg hist_pending;
  reg [7:0] init_cnt;

  wire wr = psel & penable & pwrite;
  wire init_done = init_busy && (init_cnt == 8'h00);
  // Start strobe lets the view follow in the same cycle that busy rises
  wire init_start = wr && !init_busy && (paddr == `DMTH_OFF_CTRL) && pwdata[0];

  // Register writes; init restores factory selectors
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      status_sel <= `DMTH_RST_STATUS_SEL;
      mon_sel1 <= `DMTH_RST_MON1;
      mon_sel2 <= `DMTH_RST_MON2;
      mon_sel3 <= `DMTH_RST_MON3;
      ref_src <= `DMTH_SRC_KEYPAD1;
      cmd_freq <= 16'h0000;
      max_freq <= `DMTH_RST_MAX_FREQ;
      vin1_bipolar <= 1'b0;
      init_busy <= 1'b0;
      init_group <= 8'h00;
      init_cnt <= 8'h00;
    end
    else
    begin
      if (init_busy)
        init_cnt <= init_cnt - 8'h01;
      if (init_done)
      begin
        init_busy <= 1'b0;
        if (init_group == 8'h00 || init_group == 8'h03)
        begin
          status_sel <= `DMTH_RST_STATUS_SEL;
          mon_sel1 <= `DMTH_RST_MON1;
          mon_sel2 <= `DMTH_RST_MON2;
          mon_sel3 <= `DMTH_RST_MON3;
        end
        if (init_group == 8'h00 || init_group == 8'h01)
        begin
          ref_src <= `DMTH_SRC_KEYPAD1;
          cmd_freq <= 16'h0000;
          max_freq <= `DMTH_RST_MAX_FREQ;
        end
        if (init_group == 8'h00 || init_group == 8'h02)
          vin1_bipolar <= 1'b0;
      end
      else if (wr && !init_busy)
      begin
        case (paddr)
          `DMTH_OFF_CTRL:
          begin
            vin1_bipolar <= pwdata[1];
            if (pwdata[0])
            begin
              init_busy <= 1'b1;
              init_group <= pwdata[15:8];
              init_cnt <= `DMTH_INIT_CYCLES;
            end
          end
          `DMTH_OFF_STATUS_SEL: status_sel <= pwdata[4:0];
          `DMTH_OFF_MON_SEL:
          begin
            mon_sel1 <= pwdata[4:0];
            mon_sel2 <= pwdata[12:8];
            mon_sel3 <= pwdata[20:16];
          end
          `DMTH_OFF_REF_SRC:
            if (pwdata[3:0] <= `DMTH_SRC_LAST)
              ref_src <= pwdata[3:0];
          `DMTH_OFF_CMD_FREQ:
            if (pwdata[15:0] <= max_freq)
              cmd_freq <= pwdata[15:0];
          `DMTH_OFF_MAX_FREQ: max_freq <= pwdata[15:0];
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Quantity selection
  // ----------------------------------------
  function [15:0] pick;
    input [4:0] sel;
    input [15:0] f;
    input [15:0] c;
    input [15:0] v;
    input [15:0] o;
    begin
      case (sel)
        5'h00: pick = f;
        5'h01: pick = f;
        5'h02: pick = c;
        5'h03: pick = v;
        default: pick = o;
      endcase
    end
  endfunction

  // Stopped drive shows the reference in place of output frequency
  wire [15:0] shown_freq = run_lvl ? meas_freq : freq_ref;

  // Status item is computed regardless of view mode
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      status_value <= 16'h0000;
      status_unit <= `DMTH_UNIT_HZ;
      mon_line1 <= 16'h0000;
      mon_line2 <= 16'h0000;
      mon_line3 <= 16'h0000;
    end
    else
    begin
      status_value <= pick(status_sel, shown_freq, meas_curr, meas_volt, meas_other);
      if (status_sel == `DMTH_SEL_FREQ)
        status_unit <= `DMTH_UNIT_HZ;
      else if (status_sel == `DMTH_SEL_CURR)
        status_unit <= `DMTH_UNIT_AMP;
      else
        status_unit <= `DMTH_UNIT_OTHER;
      mon_line1 <= pick(mon_sel1, shown_freq, meas_curr, meas_volt, meas_other);
      mon_line2 <= pick(mon_sel2, shown_freq, meas_curr, meas_volt, meas_other);
      mon_line3 <= pick(mon_sel3, shown_freq, meas_curr, meas_volt, meas_other);
    end
  end

  // ----------------------------------------
  // Trip view and snapshot
  // ----------------------------------------
  reg [2:0] saved_view;
  reg [7:0] cur_code;
  reg [3:0] cur_count;
  reg [15:0] snap_freq;
  reg [15:0] snap_curr;
  reg snap_run;
  wire release_ev = ev_stop | ev_term;

  // Any trip event is captured; reset- and power-off trips arrive the same way
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      view_mode <= monitor_view_mode;
      saved_view <= monitor_view_mode;
      trip_list_shown <= 1'b0;
      cur_code <= 8'h00;
      cur_count <= 4'h0;
      snap_freq <= 16'h0000;
      snap_curr <= 16'h0000;
      snap_run <= 1'b0;
      hist_pending <= 1'b0;
    end
    else
    begin
      hist_pending <= 1'b0;
      if (ev_trip)
      begin
        if (view_mode != trip_view_mode)
          saved_view <= view_mode;
        view_mode <= trip_view_mode;
        cur_code <= trip_code;
        cur_count <= trip_count;
        snap_freq <= meas_freq;
        snap_curr <= meas_curr;
        snap_run <= run_lvl;
        trip_list_shown <= 1'b0;
      end
      else if (view_mode == trip_view_mode && release_ev)
      begin
        hist_pending <= 1'b1;
        view_mode <= saved_view;
        trip_list_shown <= 1'b0;
      end
      else if (view_mode == trip_view_mode && ev_enter && cur_count > 4'h1)
        trip_list_shown <= ~trip_list_shown;
      else if (init_start || init_busy)
        view_mode <= init_select_mode;
    end
  end

  // ----------------------------------------
  // Trip history
  // ----------------------------------------
  // Entry: {run, count, code, curr, freq}
  reg [44:0] hist [0:`DMTH_HIST_DEPTH-1];
  reg [2:0] hist_cnt;
  integer i;

  // No reset on the history so it models non-volatile storage
  always @(posedge pclk)
  begin
    if (hist_pending)
    begin
      for (i = `DMTH_HIST_DEPTH - 1; i > 0; i = i - 1)
        hist[i] <= hist[i-1];
      hist[0] <= {snap_run, cur_count, cur_code, snap_curr, snap_freq};
    end
  end

  // Fill count saturates at depth; oldest falls off the end
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      hist_cnt <= 3'h0;
    else if (hist_pending && hist_cnt < `DMTH_HIST_DEPTH)
      hist_cnt <= hist_cnt + 3'h1;
  end

  // ----------------------------------------
  // Frequency reference
  // ----------------------------------------
  reg [15:0] next_freq_ref;
  reg next_reverse;

  // Source select with clamp to the maximum
  always @*
  begin
    next_freq_ref = freq_ref;
    next_reverse = 1'b0;
    case (ref_src)
      `DMTH_SRC_KEYPAD1:
        if (ev_enter && view_mode != trip_view_mode)
          next_freq_ref = cmd_freq;
      `DMTH_SRC_KEYPAD2:
      begin
        if (ev_up && freq_ref < max_freq)
          next_freq_ref = freq_ref + `DMTH_FREQ_STEP;
        else if (ev_down && freq_ref != 16'h0000)
          next_freq_ref = freq_ref - `DMTH_FREQ_STEP;
      end
      `DMTH_SRC_VIN1:
      begin
        next_freq_ref = ext_ref;
        next_reverse = vin1_bipolar & ext_ref_neg;
      end
      default: next_freq_ref = ext_ref;
    endcase
    if (next_freq_ref > max_freq)
      next_freq_ref = max_freq;
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      freq_ref <= 16'h0000;
      freq_reverse <= 1'b0;
    end
    else
    begin
      freq_ref <= next_freq_ref;
      freq_reverse <= next_reverse;
    end
  end

  // ----------------------------------------
  // APB slave: zero wait states
  // ----------------------------------------
  reg [31:0] rd_mux;
  reg rd_err;
  wire [7:0] hoff = paddr - `DMTH_OFF_HIST0;

  // Read decode; unmapped answers error and zero
  always @*
  begin
    rd_mux = 32'h00000000;
    rd_err = 1'b0;
    case (paddr)
      `DMTH_OFF_CTRL: rd_mux = {16'h0000, init_group, 6'h00, vin1_bipolar, init_busy};
      `DMTH_OFF_STATUS_SEL: rd_mux = {27'h0000000, status_sel};
      `DMTH_OFF_MON_SEL: rd_mux = {11'h000, mon_sel3, 3'h0, mon_sel2, 3'h0, mon_sel1};
      `DMTH_OFF_REF_SRC: rd_mux = {28'h0000000, ref_src};
      `DMTH_OFF_CMD_FREQ: rd_mux = {16'h0000, cmd_freq};
      `DMTH_OFF_MAX_FREQ: rd_mux = {16'h0000, max_freq};
      `DMTH_OFF_FREQ_REF: rd_mux = {15'h0000, freq_reverse, freq_ref};
      `DMTH_OFF_VIEW: rd_mux = {28'h0000000, trip_list_shown, view_mode};
      `DMTH_OFF_TRIP_NOW: rd_mux = {19'h00000, snap_run, cur_count, cur_code};
      `DMTH_OFF_HIST_CNT: rd_mux = {29'h00000000, hist_cnt};
      default:
      begin
        if (paddr >= `DMTH_OFF_HIST0 && hoff < 8'h28 && hoff[1:0] == 2'b00)
        begin
          if (hoff[2])
            rd_mux = {19'h00000, hist[hoff[5:3]][44:32]};
          else
            rd_mux = hist[hoff[5:3]][31:0];
        end
        else
          rd_err = 1'b1;
      end
    endcase
  end

  // Answer in the first access cycle
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & rd_err;
      if (psel && !penable && !pwrite)
        prdata <= rd_mux;
    end
  end

endmodule
`default_nettype wire

// ---- dmth_map.vh ----
`ifndef DMTH_MAP_VH
`define DMTH_MAP_VH

// ----------------------------------------
// APB register byte offsets
// ----------------------------------------
`define DMTH_OFF_CTRL       8'h00
`define DMTH_OFF_STATUS_SEL 8'h04
`define DMTH_OFF_MON_SEL    8'h08
`define DMTH_OFF_REF_SRC    8'h0C
`define DMTH_OFF_CMD_FREQ   8'h10
`define DMTH_OFF_MAX_FREQ   8'h14
`define DMTH_OFF_FREQ_REF   8'h18
`define DMTH_OFF_VIEW       8'h1C
`define DMTH_OFF_TRIP_NOW   8'h20
`define DMTH_OFF_HIST_CNT   8'h24
`define DMTH_OFF_HIST0      8'h40

// ----------------------------------------
// Reset values and codes
// ----------------------------------------
`define DMTH_RST_STATUS_SEL 5'h00
`define DMTH_RST_MON1       5'h00
`define DMTH_RST_MON2       5'h02
`define DMTH_RST_MON3       5'h03
`define DMTH_RST_MAX_FREQ   16'h1770
`define DMTH_UNIT_HZ        2'h0
`define DMTH_UNIT_AMP       2'h1
`define DMTH_UNIT_OTHER     2'h2
`define DMTH_SEL_FREQ       5'h00
`define DMTH_SEL_SPEED      5'h01
`define DMTH_SEL_CURR       5'h02
`define DMTH_SRC_KEYPAD1    4'h0
`define DMTH_SRC_KEYPAD2    4'h1
`define DMTH_SRC_VIN1       4'h2
`define DMTH_SRC_LAST       4'h9
`define DMTH_HIST_DEPTH     5
`define DMTH_INIT_CYCLES    8'h10
`define DMTH_FREQ_STEP      16'h0001

`endif

// ---- dmth_keypad_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// ----
// Keypad, terminal and trip pin model
// ----
module dmth_keypad_model
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic req,
  input wire logic [2:0] sel,
  output logic ack,
  output logic [5:0] keys
);
  logic [3:0] cnt;
  // Pin high 5 cycles, low 5 before ack: the input synchroniser must see both levels
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt <= 4'h0;
      keys <= 6'h00;
      ack <= 1'b0;
    end
    else
    begin
      ack <= 1'b0;
      if (cnt != 4'h0)
      begin
        cnt <= cnt - 4'h1;
        if (cnt == 4'h6)
          keys <= 6'h00;
        if (cnt == 4'h1)
          ack <= 1'b1;
      end
      else if (req && !ack)
      begin
        keys <= 6'h01 << sel;
        cnt <= 4'hA;
      end
    end
  end
endmodule
`default_nettype wire

// ---- dmth_top_sva.sv ----
`timescale 1ns/100ps
`default_nettype none
module dmth_top_sva
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic running,
  input wire logic trip_event,
  input wire logic key_stop_reset,
  input wire logic init_busy,
  input wire logic trip_list_shown,
  input wire logic [15:0] freq_ref,
  input wire logic [1:0] status_unit,
  input wire logic [2:0] view_mode
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ----
  // Bus and reset checks
  // ----
  chk_zero_wait:
    assert property (psel && penable |-> pready) else $error("no ready in access");
  chk_ready_access:
    assert property (pready |-> psel && penable) else $error("stray ready");
  chk_err_ready:
    assert property (pslverr |-> pready) else $error("error without ready");
  chk_reset_vals:
    assert property ($rose(presetn) |-> freq_ref == 16'h0000 && status_unit == 2'h0)
    else $error("bad values after reset");
  // ----
  // Trip and init sequencing
  // ----
  chk_trip_entry:
    assert property ($rose(trip_event) && running |-> ##[4:7] view_mode == 3'h2)
    else $error("trip view not entered");
  chk_trip_release:
    assert property (view_mode == 3'h2 && $rose(key_stop_reset) |-> ##[4:7] view_mode != 3'h2)
    else $error("trip view not left");
  chk_list_in_trip:
    assert property (trip_list_shown |-> view_mode == 3'h2) else $error("list outside trip");
  chk_init_len:
    assert property ($rose(init_busy) |-> init_busy [*8] ##[1:12] !init_busy)
    else $error("init length wrong");
  chk_init_view:
    assert property (init_busy || $fell(init_busy) |-> view_mode == 3'h4)
    else $error("init view wrong");
  // Main scenarios reached
  cov_list: cover property ($rose(trip_list_shown));
  cov_init: cover property ($fell(init_busy));
  cov_err: cover property (pslverr);
endmodule
bind dmth_top dmth_top_sva dmth_top_sva_inst (.*);
`default_nettype wire

// ---- drive_monitor_trip_history_tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "dmth_map.vh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module drive_monitor_trip_history_tb_top;
  localparam logic [15:0] MAXF = `DMTH_RST_MAX_FREQ;
  logic pclk, presetn, psel, penable, pwrite, running, ext_ref_neg, req, ack, err;
  logic pready, pslverr, trip_list_shown, freq_reverse, init_busy;
  logic [7:0] paddr, trip_code, init_group;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] trip_count;
  logic [15:0] meas_freq, meas_curr, meas_volt, meas_other, ext_ref, status_value, v;
  logic [15:0] mon_line1, mon_line2, mon_line3, freq_ref;
  logic [1:0] status_unit;
  logic [2:0] view_mode, sel;
  logic [5:0] keys;
  logic [7:0] codes [0:5];
  int n_mismatch = 0, n_compared = 0, cyc = 0, i;
  // ----
  // Clock, design, keypad model, watchdog
  // ----
  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  dmth_top dmth_top_inst (.key_enter(keys[0]), .key_stop_reset(keys[1]), .key_up(keys[2]),
    .key_down(keys[3]), .term_reset(keys[4]), .trip_event(keys[5]), .*);
  dmth_keypad_model dmth_keypad_model_inst (.pclk(pclk), .presetn(presetn), .req(req),
    .sel(sel), .ack(ack), .keys(keys));
  // Cuts a hang short; the whole run needs well under a thousand cycles
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      n_mismatch++;
      final_report();
    end
  end
  // ----
  // Tasks and expectation functions
  // ----
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Key codes: 0 enter, 1 stop, 2 up, 3 down, 4 terminal, 5 trip
  task automatic press(input logic [2:0] s);
    @(posedge pclk);
    sel <= s;
    req <= 1'b1;
    do @(posedge pclk); while (ack !== 1'b1);
    req <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask
  function automatic logic [15:0] clampf(input logic [15:0] x);
    return (x > MAXF) ? MAXF : x;
  endfunction
  function automatic logic [31:0] tripw(input logic [7:0] c, input logic [3:0] n);
    return {19'h00000, 1'b1, n, c};
  endfunction
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ----
  // Test sequence
  // ----
  initial
  begin
    {psel, penable, pwrite, req, running, ext_ref_neg} = 6'h00;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    sel = 3'h0;
    trip_code = 8'h00;
    trip_count = 4'h1;
    presetn = 1'b0;
    rd = $urandom(32'h29AE);
    {meas_freq, meas_curr} = $urandom;
    {meas_volt, meas_other} = $urandom;
    ext_ref = 16'h0000;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `DMTH_OFF_STATUS_SEL, 32'h0);
    `CHK("status_sel", 32'h00000000, rd)
    apb(1'b0, `DMTH_OFF_MON_SEL, 32'h0);
    `CHK("mon_sel", 32'h00030200, rd)
    apb(1'b0, `DMTH_OFF_FREQ_REF, 32'h0);
    `CHK("freq_ref", 32'h00000000, rd)
    apb(1'b0, 8'hFC, 32'h0);
    `CHK("unmapped_err", 1'b1, err)
    $display("test reset done");
    // Status item and monitor lines follow their selectors
    apb(1'b1, `DMTH_OFF_STATUS_SEL, 32'h2);
    apb(1'b1, `DMTH_OFF_MON_SEL, 32'h00000402);
    repeat (3) @(posedge pclk);
    `CHK("status_value", meas_curr, status_value)
    `CHK("status_unit", `DMTH_UNIT_AMP, status_unit)
    `CHK("mon_line1", meas_curr, mon_line1)
    `CHK("mon_line2", meas_other, mon_line2)
    `CHK("mon_line3", 16'h0000, mon_line3)
    apb(1'b1, `DMTH_OFF_STATUS_SEL, 32'h0);
    repeat (3) @(posedge pclk);
    `CHK("status_unit", `DMTH_UNIT_HZ, status_unit)
    $display("test status done");
    // Reference sources, clamp and keypad entry
    apb(1'b1, `DMTH_OFF_REF_SRC, 32'hA);
    apb(1'b0, `DMTH_OFF_REF_SRC, 32'h0);
    `CHK("ref_src", 32'h00000000, rd)
    v = 16'($urandom_range(MAXF));
    apb(1'b1, `DMTH_OFF_CMD_FREQ, {16'h0000, v});
    `CHK("freq_ref", 16'h0000, freq_ref)
    press(3'h0);
    `CHK("freq_ref", v, freq_ref)
    apb(1'b1, `DMTH_OFF_CMD_FREQ, {16'h0000, MAXF + 16'h0001});
    apb(1'b0, `DMTH_OFF_CMD_FREQ, 32'h0);
    `CHK("cmd_freq", {16'h0000, v}, rd)
    apb(1'b1, `DMTH_OFF_REF_SRC, 32'h1);
    press(3'h2);
    `CHK("freq_up", clampf(v + 16'h0001), freq_ref)
    press(3'h3);
    `CHK("freq_down", clampf(v + 16'h0001) - 16'h0001, freq_ref)
    for (i = 3; i <= 9; i++)
    begin
      ext_ref <= 16'($urandom);
      apb(1'b1, `DMTH_OFF_REF_SRC, 32'(i));
      repeat (3) @(posedge pclk);
      `CHK("freq_ext", clampf(ext_ref), freq_ref)
    end
    apb(1'b1, `DMTH_OFF_REF_SRC, 32'h2);
    apb(1'b1, `DMTH_OFF_CTRL, 32'h2);
    ext_ref_neg <= 1'b1;
    repeat (3) @(posedge pclk);
    `CHK("reverse_bipolar", 1'b1, freq_reverse)
    apb(1'b1, `DMTH_OFF_CTRL, 32'h0);
    repeat (3) @(posedge pclk);
    `CHK("reverse_unipolar", 1'b0, freq_reverse)
    $display("test reference done");
    // Six trips: view, snapshot, list toggle, release and history depth
    running <= 1'b1;
    for (i = 0; i < 6; i++)
    begin
      codes[i] = 8'($urandom);
      trip_code <= codes[i];
      trip_count <= (i == 0) ? 4'h2 : 4'h1;
      press(3'h5);
      `CHK("view_trip", 3'h2, view_mode)
      `CHK("status_trip", meas_freq, status_value)
      apb(1'b0, `DMTH_OFF_TRIP_NOW, 32'h0);
      `CHK("trip_now", tripw(codes[i], trip_count), rd)
      if (i == 0)
      begin
        press(3'h0);
        `CHK("list_on", 1'b1, trip_list_shown)
        press(3'h0);
        `CHK("list_off", 1'b0, trip_list_shown)
      end
      press(i[0] ? 3'h4 : 3'h1);
      `CHK("view_back", 3'h0, view_mode)
    end
    apb(1'b0, `DMTH_OFF_HIST_CNT, 32'h0);
    `CHK("hist_cnt", 32'h00000005, rd)
    apb(1'b0, `DMTH_OFF_HIST0, 32'h0);
    `CHK("hist0_meas", {meas_curr, meas_freq}, rd)
    apb(1'b0, `DMTH_OFF_HIST0 + 8'h04, 32'h0);
    `CHK("hist0", tripw(codes[5], 4'h1), rd)
    apb(1'b0, `DMTH_OFF_HIST0 + 8'h0C, 32'h0);
    `CHK("hist1", tripw(codes[4], 4'h1), rd)
    apb(1'b0, `DMTH_OFF_HIST0 + 8'h24, 32'h0);
    `CHK("hist4", tripw(codes[1], 4'h1), rd)
    $display("test trips done");
    // Initialisation restores factory selector and returns to its item
    running <= 1'b0;
    apb(1'b1, `DMTH_OFF_STATUS_SEL, 32'h2);
    apb(1'b1, `DMTH_OFF_CTRL, 32'h00000101);
    do @(posedge pclk); while (init_busy !== 1'b0);
    `CHK("init_group", 8'h01, init_group)
    apb(1'b0, `DMTH_OFF_STATUS_SEL, 32'h0);
    `CHK("status_kept", 32'h00000002, rd)
    apb(1'b0, `DMTH_OFF_REF_SRC, 32'h0);
    `CHK("src_default", 32'h00000000, rd)
    apb(1'b1, `DMTH_OFF_CTRL, 32'h1);
    @(posedge pclk);
    `CHK("init_busy", 1'b1, init_busy)
    do @(posedge pclk); while (init_busy !== 1'b0);
    `CHK("view_init", 3'h4, view_mode)
    `CHK("init_group", 8'h00, init_group)
    apb(1'b0, `DMTH_OFF_STATUS_SEL, 32'h0);
    `CHK("status_sel", 32'h00000000, rd)
    $display("test init done");
    // History survives a reset in mid-run
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `DMTH_OFF_HIST0 + 8'h04, 32'h0);
    `CHK("hist_kept", tripw(codes[5], 4'h1), rd)
    $display("test retention done");
    final_report();
  end
endmodule
`default_nettype wire
